//--- include/monitor_adc_regs.svh
// Behaviour
// - Results are 7-bit unsigned codes, 0 to 127.
// - Active state repeats supply, temp, supply, lowside, supply, highside.
// - Every result passes a moving-average filter of configurable length.
// - Supply uses its own filter setting; all other channels share another.
// - Supply, drive-supply and temperature results land in their status registers.
// - Writing 1 to ondemand_request inserts one conversion of the selected source.
// - On-demand sources: digital current, logic regulator output, buck output.
// - A running conversion finishes before the on-demand one starts.
// - On-demand completion stores ondemand_result and sets ondemand_done_flag.
// - After on-demand conversion the loop resumes at the interrupted step.
// - A config write replaces every field; absent fields take defaults.
// - Supply volts are 0.581 times code plus 5.52.
// - Temperature in Celsius is twice the code minus 94.
// - Drive-supply volts are code times 16 over 127.
// - Digital current result step is 0.24 mA.
// - Regulator or buck code is fraction of target voltage, full scale 127.
// - Over-temperature flags readable; shutdown disable bit suppresses shutdown action.
`ifndef MONITOR_ADC_REGS_SVH
`define MONITOR_ADC_REGS_SVH

// ---------------------------------------------
// Register offsets
// ---------------------------------------------
`define OFF_CONFIG      8'h00
`define OFF_SUPPLY      8'h04
`define OFF_PUMP        8'h08
`define OFF_TEMP        8'h0c
`define OFF_CONV_STATUS 8'h10

// ---------------------------------------------
// Field positions and reset values
// ---------------------------------------------
`define CFG_SUP_FILT_LSB 0
`define CFG_SHR_FILT_LSB 2
`define CFG_OD_SEL_LSB   4
`define CFG_OD_REQ_BIT   6
`define CFG_OVERTEMP_SHUTDOWN_DISABLE_BIT  7
`define CFG_RESET        8'h00
`define PUMP_HS_LSB      8
`define TEMP_OTW_BIT     8
`define TEMP_OTS_BIT     9
`define ST_DONE_BIT      8
`define ST_BUSY_BIT      9
`define ST_STEP_LSB      12
`define LOOP_LAST        3'd5

`endif

//--- include/monitor_adc_pkg.sv
`default_nettype none
package monitor_adc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } seq_state_t;

  typedef enum logic [2:0] {
    CH_SUPPLY = 3'h0,
    CH_TEMP   = 3'h1,
    CH_LS     = 3'h2,
    CH_HS     = 3'h3,
    CH_DCURR  = 3'h4,
    CH_LREG   = 3'h5,
    CH_BUCK   = 3'h6
  } chan_t;

endpackage : monitor_adc_pkg
`default_nettype wire

//--- include/filt_if.sv
`default_nettype none
interface filt_if #(parameter int W = 7);
  logic         sample_valid;
  logic [W-1:0] sample;
  logic [1:0]   window;
  logic [W-1:0] result;
  modport feed (output sample_valid, output sample, output window, input result);
  modport filt (input sample_valid, input sample, input window, output result);
endinterface : filt_if
`default_nettype wire

//--- rtl/moving_avg_filter.sv
`default_nettype none
module moving_avg_filter #(
  parameter int W     = 7,
  parameter int DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  filt_if.filt     f
);
  localparam int SW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] hist;
    logic [W-1:0]            avg;
  } filt_state_t;

  filt_state_t        s_reg;
  filt_state_t        s_next;
  logic [W+SW-1:0]    sum;

  // Window code n averages 2**n samples; history starts at zero so the
  // first readings after reset ramp up.
  always_comb begin
    s_next = s_reg;
    sum    = '0;
    if (f.sample_valid) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        s_next.hist[i] = s_reg.hist[i-1];
      end
      s_next.hist[0] = f.sample;
      for (int i = 0; i < DEPTH; i++) begin
        if (i < (32'd1 << f.window)) begin
          sum = sum + {{SW{1'b0}}, s_next.hist[i]};
        end
      end
      s_next.avg = W'(sum >> f.window);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign f.result = s_reg.avg;
endmodule : moving_avg_filter
`default_nettype wire

//--- rtl/monitor_adc_sequencer.sv
`default_nettype none
`include "monitor_adc_regs.svh"
module monitor_adc_sequencer
  import monitor_adc_pkg::*;
#(
  parameter int RES_W      = 7,
  parameter int FILT_DEPTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             active_state,
  input  wire logic             adc_eoc,
  input  wire logic [RES_W-1:0] adc_result,
  input  wire logic             ot_warning_in,
  input  wire logic             ot_shutdown_in,
  output logic                  adc_start,
  output logic [2:0]            adc_channel,
  output logic                  overtemp_shutdown_action
);
  localparam int NF = 5;
  localparam int OD = 4;

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  typedef struct packed {
    seq_state_t       st;
    logic [2:0]       step;
    logic             act_d;
    logic             od_pend;
    logic [1:0]       od_src;
    logic             od_run;
    chan_t            chan;
    logic             start;
    logic [2:0]       eoc_sync;
    logic [RES_W-1:0] res_s1;
    logic [RES_W-1:0] res_s2;
    logic [1:0]       otw_sync;
    logic [1:0]       ots_sync;
    logic [1:0]       sup_filt;
    logic [1:0]       shr_filt;
    logic [1:0]       od_sel;
    logic             overtemp_shutdown_disable;
    logic             done;
    logic [NF-1:0]    fvalid;
    logic [RES_W-1:0] sample;
    logic [31:0]      rdata;
    logic             slverr;
  } seq_reg_t;

  seq_reg_t             r_reg;
  seq_reg_t             r_next;
  logic [RES_W-1:0]     res [NF];
  logic                 eoc_rise;
  logic                 setup;
  logic                 cfg_wr;
  logic                 req_wr;
  logic [2:0]           step_cur;

  function automatic chan_t loop_chan(input logic [2:0] s);
    unique case (s)
      3'd1:    loop_chan = CH_TEMP;
      3'd3:    loop_chan = CH_LS;
      3'd5:    loop_chan = CH_HS;
      default: loop_chan = CH_SUPPLY;
    endcase
  endfunction : loop_chan

  function automatic chan_t od_chan(input logic [1:0] sel);
    unique case (sel)
      2'd1:    od_chan = CH_LREG;
      2'd2:    od_chan = CH_BUCK;
      default: od_chan = CH_DCURR;
    endcase
  endfunction : od_chan

  // The eoc edge detect compares the second and third flops of its synchroniser
  assign eoc_rise = r_reg.eoc_sync[1] & ~r_reg.eoc_sync[2];
  assign setup    = psel & ~penable;
  assign cfg_wr   = psel & penable & pwrite & ~r_reg.slverr & (paddr == `OFF_CONFIG) & pstrb[0];
  assign req_wr   = cfg_wr & pwdata[`CFG_OD_REQ_BIT];
  assign step_cur = (active_state & ~r_reg.act_d) ? 3'h0 : r_reg.step;

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------
  always_comb begin
    r_next          = r_reg;
    r_next.start    = 1'b0;
    r_next.fvalid   = '0;
    r_next.act_d    = active_state;
    r_next.eoc_sync = {r_reg.eoc_sync[1:0], adc_eoc};
    r_next.res_s1   = adc_result;
    r_next.res_s2   = r_reg.res_s1;
    r_next.otw_sync = {r_reg.otw_sync[0], ot_warning_in};
    r_next.ots_sync = {r_reg.ots_sync[0], ot_shutdown_in};
    r_next.step     = step_cur;

    unique case (r_reg.st)
      ST_IDLE: begin
        // Nothing new starts outside the active state
        if (active_state) begin
          r_next.start = 1'b1;
          r_next.st    = ST_CONV;
          if (r_reg.od_pend) begin
            r_next.chan    = od_chan(r_reg.od_src);
            r_next.od_run  = 1'b1;
            r_next.od_pend = 1'b0;
          end else begin
            r_next.chan = loop_chan(step_cur);
          end
        end
      end
      ST_CONV: begin
        // A pending request waits here for end of conversion
        if (eoc_rise) begin
          r_next.sample = r_reg.res_s2;
          r_next.st     = ST_IDLE;
          if (r_reg.od_run) begin
            r_next.fvalid[OD] = 1'b1;
            r_next.od_run     = 1'b0;
            // Loop position untouched, so the loop resumes where it left
            r_next.step       = r_reg.step;
          end else begin
            // Codes are stored raw; software applies the channel scaling
            r_next.fvalid[3'(r_reg.chan)] = 1'b1;
            r_next.step = (r_reg.step == `LOOP_LAST) ? 3'h0 : r_reg.step + 3'h1;
          end
        end
      end
    endcase

    // Done waits one edge for the filtered result to land, so a poll that
    // sees it never reads a stale code; a queued newer request keeps it low
    if (r_reg.fvalid[OD] && !r_reg.od_pend) begin
      r_next.done = 1'b1;
    end

    // Bus write comes last so a new request overrides a completion
    if (cfg_wr) begin
      r_next.sup_filt = pwdata[`CFG_SUP_FILT_LSB +: 2];
      r_next.shr_filt = pwdata[`CFG_SHR_FILT_LSB +: 2];
      r_next.od_sel   = pwdata[`CFG_OD_SEL_LSB +: 2];
      r_next.overtemp_shutdown_disable  = pwdata[`CFG_OVERTEMP_SHUTDOWN_DISABLE_BIT];
    end
    if (req_wr) begin
      r_next.od_pend = 1'b1;
      r_next.od_src  = pwdata[`CFG_OD_SEL_LSB +: 2];
      r_next.done    = 1'b0;
    end

    // Read data is captured in the setup phase so prdata comes from a flop
    if (setup) begin
      r_next.rdata  = '0;
      r_next.slverr = 1'b0;
      unique case (paddr)
        `OFF_CONFIG: begin
          r_next.rdata[`CFG_SUP_FILT_LSB +: 2] = r_reg.sup_filt;
          r_next.rdata[`CFG_SHR_FILT_LSB +: 2] = r_reg.shr_filt;
          r_next.rdata[`CFG_OD_SEL_LSB +: 2]   = r_reg.od_sel;
          r_next.rdata[`CFG_OVERTEMP_SHUTDOWN_DISABLE_BIT]       = r_reg.overtemp_shutdown_disable;
          r_next.slverr = 1'b0;
        end
        `OFF_SUPPLY: begin
          r_next.rdata[RES_W-1:0] = res[0];
          r_next.slverr = pwrite;
        end
        `OFF_PUMP: begin
          r_next.rdata[RES_W-1:0]              = res[2];
          r_next.rdata[`PUMP_HS_LSB +: RES_W]  = res[3];
          r_next.slverr = pwrite;
        end
        `OFF_TEMP: begin
          r_next.rdata[RES_W-1:0]    = res[1];
          r_next.rdata[`TEMP_OTW_BIT] = r_reg.otw_sync[1];
          r_next.rdata[`TEMP_OTS_BIT] = r_reg.ots_sync[1];
          r_next.slverr = pwrite;
        end
        `OFF_CONV_STATUS: begin
          // Current and regulator codes are raw fractions of full scale
          r_next.rdata[RES_W-1:0]      = res[OD];
          r_next.rdata[`ST_DONE_BIT]   = r_reg.done;
          r_next.rdata[`ST_BUSY_BIT]   = r_reg.od_pend | r_reg.od_run;
          r_next.rdata[`ST_STEP_LSB +: 3] = r_reg.step;
          r_next.slverr = pwrite;
        end
        default: begin
          r_next.slverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg          <= '0;
      r_reg.st       <= ST_IDLE;
      r_reg.chan     <= CH_SUPPLY;
      r_reg.sup_filt <= 2'(`CFG_RESET >> `CFG_SUP_FILT_LSB);
      r_reg.shr_filt <= 2'(`CFG_RESET >> `CFG_SHR_FILT_LSB);
      r_reg.od_sel   <= 2'(`CFG_RESET >> `CFG_OD_SEL_LSB);
      r_reg.overtemp_shutdown_disable  <= 1'(`CFG_RESET >> `CFG_OVERTEMP_SHUTDOWN_DISABLE_BIT);
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------
  // Filters: supply, temp, lowside, highside, on-demand
  // ---------------------------------------------
  for (genvar i = 0; i < NF; i++) begin : g_filt
    filt_if #(.W(RES_W)) fi ();
    assign fi.sample_valid = r_reg.fvalid[i];
    assign fi.sample       = r_reg.sample;
    assign fi.window       = (i == 0) ? r_reg.sup_filt : r_reg.shr_filt;
    assign res[i]          = fi.result;
    moving_avg_filter #(.W(RES_W), .DEPTH(FILT_DEPTH)) u_filt (
      .pclk    (pclk),
      .presetn (presetn),
      .f       (fi)
    );
  end

  // ---------------------------------------------
  // Outputs
  // ---------------------------------------------
  assign prdata      = r_reg.rdata;
  assign pslverr     = r_reg.slverr;
  assign pready      = 1'b1;
  assign adc_start   = r_reg.start;
  assign adc_channel = r_reg.chan;
  // Disabling shutdown leaves the flag visible but blocks the action
  assign overtemp_shutdown_action = r_reg.ots_sync[1] & ~r_reg.overtemp_shutdown_disable;

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_sample_capture;
    (r_reg.st == ST_CONV && eoc_rise) |=> (r_reg.sample == $past(r_reg.res_s2)) && (r_reg.fvalid != '0);
  endproperty
  a_sample_capture: assert property (p_sample_capture) else $error("result not captured at eoc");

  property p_loop_wrap;
    (r_reg.st == ST_CONV && eoc_rise && !r_reg.od_run && r_reg.step == `LOOP_LAST && active_state)
      |=> (r_reg.step == 3'h0) and (active_state |=> (adc_channel == CH_SUPPLY || r_reg.od_run));
  endproperty
  a_loop_wrap: assert property (p_loop_wrap) else $error("loop did not wrap to first step");

  property p_filter_windows;
    (g_filt[0].fi.window == r_reg.sup_filt) && (g_filt[OD].fi.window == r_reg.shr_filt);
  endproperty
  a_filter_windows: assert property (p_filter_windows) else $error("filter setting misrouted");

  property p_supply_route;
    r_reg.fvalid[0] |-> (r_reg.chan == CH_SUPPLY) && !r_reg.od_run;
  endproperty
  a_supply_route: assert property (p_supply_route) else $error("supply result from wrong channel");

  property p_request_taken;
    req_wr |=> r_reg.od_pend && !r_reg.done;
  endproperty
  a_request_taken: assert property (p_request_taken) else $error("request not recorded");

  property p_wait_eoc;
    (r_reg.st == ST_CONV && !eoc_rise) |=> !adc_start;
  endproperty
  a_wait_eoc: assert property (p_wait_eoc) else $error("start issued before end of conversion");

  property p_od_done;
    (r_reg.st == ST_CONV && eoc_rise && r_reg.od_run && !req_wr)
      |=> r_reg.fvalid[OD] ##1 (r_reg.done || $past(r_reg.od_pend) || $past(req_wr));
  endproperty
  a_od_done: assert property (p_od_done) else $error("done flag not set on completion");

  property p_resume_step;
    (adc_start && r_reg.od_run) |=> (r_reg.step == $past(r_reg.step)) || $rose(active_state);
  endproperty
  a_resume_step: assert property (p_resume_step) else $error("loop step moved during on-demand");

  property p_od_source;
    (adc_start && r_reg.od_run) |-> (adc_channel == CH_DCURR || adc_channel == CH_LREG || adc_channel == CH_BUCK);
  endproperty
  a_od_source: assert property (p_od_source) else $error("on-demand source out of range");

  property p_shutdown_mask;
    r_reg.overtemp_shutdown_disable |-> !overtemp_shutdown_action;
  endproperty
  a_shutdown_mask: assert property (p_shutdown_mask) else $error("shutdown not suppressed");

  property p_active_entry;
    (active_state && !r_reg.act_d && r_reg.st == ST_IDLE) |=> adc_start && r_reg.step == 3'h0;
  endproperty
  a_active_entry: assert property (p_active_entry) else $error("loop not restarted on entry");

  property p_no_start_inactive;
    !active_state |=> !adc_start;
  endproperty
  a_no_start_inactive: assert property (p_no_start_inactive) else $error("start while inactive");

  // Done may only rise once the on-demand filter has taken its sample
  property p_done_fresh;
    $rose(r_reg.done) |-> $past(r_reg.fvalid[OD]);
  endproperty
  a_done_fresh: assert property (p_done_fresh) else $error("done raised before result landed");

  property p_single_inject;
    (adc_start && r_reg.od_run && !$past(req_wr)) |-> !r_reg.od_pend;
  endproperty
  a_single_inject: assert property (p_single_inject) else $error("request injected more than once");

  property p_pump_route;
    (r_reg.fvalid[2] |-> r_reg.chan == CH_LS) and (r_reg.fvalid[3] |-> r_reg.chan == CH_HS);
  endproperty
  a_pump_route: assert property (p_pump_route) else $error("drive-supply result misrouted");

  // Status registers are read-only; a write there must leave config alone
  property p_write_refused;
    (psel && penable && pwrite && paddr != `OFF_CONFIG) |=> $stable(r_reg.sup_filt) && $stable(r_reg.shr_filt)
      && $stable(r_reg.od_sel) && $stable(r_reg.overtemp_shutdown_disable);
  endproperty
  a_write_refused: assert property (p_write_refused) else $error("write to status changed config");

  property p_config_readback;
    (psel && !penable && paddr == `OFF_CONFIG)
      |=> (prdata[`CFG_OD_REQ_BIT] == 1'b0) && (prdata[`CFG_OVERTEMP_SHUTDOWN_DISABLE_BIT] == $past(r_reg.overtemp_shutdown_disable));
  endproperty
  a_config_readback: assert property (p_config_readback) else $error("config readback wrong");

  property p_leave_active;
    (!active_state && r_reg.st == ST_IDLE) |=> r_reg.st == ST_IDLE;
  endproperty
  a_leave_active: assert property (p_leave_active) else $error("conversion began while inactive");

  c_od_complete: cover property (r_reg.od_run && eoc_rise ##1 r_reg.done);
  c_loop_wrap:   cover property (r_reg.step == `LOOP_LAST ##[1:50] r_reg.step == 3'h0);
  c_unmapped:    cover property (psel && penable && r_reg.slverr);
  c_req_in_conv: cover property (req_wr && r_reg.st == ST_CONV && !r_reg.od_run);
  c_od_queued:   cover property (req_wr && r_reg.od_run);
endmodule : monitor_adc_sequencer
`default_nettype wire

//--- bench/adc_model.sv
`default_nettype none
module adc_model (
  input  wire logic       pclk,
  input  wire logic       adc_start,
  input  wire logic [2:0] adc_channel,
  input  wire logic [6:0] bias,
  output logic            adc_eoc,
  output logic [6:0]      adc_result
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------
  // Converter timing
  // ---------------------------------------------
  logic [3:0] cnt_reg;
  initial begin
    cnt_reg    = 4'h0;
    adc_eoc    = 1'b0;
    adc_result = 7'h7f;
  end
  // Code is the channel number over a fixed low nibble, XORed with bias, so every source is distinct
  always @(posedge pclk) begin
    if (adc_start) begin
      cnt_reg <= 4'h8;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
    if (cnt_reg == 4'h5) begin
      adc_result <= {adc_channel, 4'h5} ^ bias;
    end
    adc_eoc <= (cnt_reg >= 4'h2) && (cnt_reg <= 4'h4);
    // Stale code is not left on the bus once the strobe is gone
    if (cnt_reg == 4'h1) begin
      adc_result <= ~adc_result;
    end
  end
endmodule : adc_model
`default_nettype wire

//--- bench/tb_monitor_adc_sequencer.sv
`default_nettype none
`include "monitor_adc_regs.svh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module tb_monitor_adc_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        active_state, adc_eoc, ot_warning_in, ot_shutdown_in;
  logic        adc_start, overtemp_shutdown_action, err;
  logic [6:0]  adc_result, bias;
  logic [2:0]  adc_channel;
  logic [2:0]  starts[$];
  int          fails, total_checks, base, k, nod;
  logic [2:0]  pat[6] = '{3'd0, 3'd1, 3'd0, 3'd2, 3'd0, 3'd3};
  logic [2:0]  odch[4] = '{3'd4, 3'd5, 3'd6, 3'd4};

  monitor_adc_sequencer monitor_adc_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .active_state(active_state), .adc_eoc(adc_eoc), .adc_result(adc_result),
    .ot_warning_in(ot_warning_in), .ot_shutdown_in(ot_shutdown_in), .adc_start(adc_start),
    .adc_channel(adc_channel), .overtemp_shutdown_action(overtemp_shutdown_action));
  adc_model adc_model_inst (
    .pclk(pclk), .adc_start(adc_start), .adc_channel(adc_channel), .bias(bias),
    .adc_eoc(adc_eoc), .adc_result(adc_result));

  // ---------------------------------------------
  // Bus tasks
  // ---------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    `CHK(nm, e, rd & m)
  endtask : rd_chk
  task automatic wait_starts(input int n);
    for (int i = 0; i < 3000 && starts.size() < n; i++) @(posedge pclk);
  endtask : wait_starts
  task automatic print_verdict;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  always @(posedge pclk) if (adc_start === 1'b1) starts.push_back(adc_channel);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    print_verdict();
  end

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    pstrb = 4'hf; active_state = 1'b0; ot_warning_in = 1'b0; ot_shutdown_in = 1'b0; bias = 7'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(`OFF_CONFIG, 32'hffffffff, 32'h0, "cfg_reset");
    xfer(1'b0, 8'h40, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    xfer(1'b1, `OFF_SUPPLY, 32'h7f);
    `CHK("ro_write_err", 1'b1, err)
    xfer(1'b1, `OFF_CONFIG, 32'h8b);
    xfer(1'b1, `OFF_CONFIG, 32'h04);
    rd_chk(`OFF_CONFIG, 32'hff, 32'h04, "cfg_replace");
    pstrb <= 4'he;
    xfer(1'b1, `OFF_CONFIG, 32'h8b);
    pstrb <= 4'hf;
    rd_chk(`OFF_CONFIG, 32'hff, 32'h04, "cfg_strobe");
    xfer(1'b1, `OFF_CONFIG, 32'h00);
    active_state <= 1'b1;
    wait_starts(13);
    rd_chk(`OFF_SUPPLY, 32'hffffffff, 32'h05, "supply");
    rd_chk(`OFF_PUMP, 32'hffffffff, 32'h3525, "pump");
    rd_chk(`OFF_TEMP, 32'h7f, 32'h15, "temp");
    // Only a write carries a request, so every selector value asks exactly once
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, `OFF_CONFIG, 32'h40 | (s << 4));
      rd_chk(`OFF_CONV_STATUS, 32'h300, 32'h200, "done_cleared");
      for (int i = 0; i < 100 && rd[8] !== 1'b1; i++) xfer(1'b0, `OFF_CONV_STATUS, 32'h0);
      `CHK("od_result", {1'b0, 1'b1, 1'b0, {odch[s], 4'h5}}, rd[9:0])
    end
    xfer(1'b1, `OFF_CONFIG, 32'h03);
    wait_starts(starts.size() + 1);
    bias <= 7'h40;
    base = starts.size();
    wait_starts(base + 6);
    rd_chk(`OFF_SUPPLY, 32'h7f, 32'h1d, "supply_avg8");
    rd_chk(`OFF_PUMP, 32'h7f7f, 32'h7565, "pump_new");
    rd_chk(`OFF_TEMP, 32'h7f, 32'h55, "temp_new");
    ot_warning_in <= 1'b1;
    ot_shutdown_in <= 1'b1;
    repeat (5) @(posedge pclk);
    `CHK("ots_action", 1'b1, overtemp_shutdown_action)
    rd_chk(`OFF_TEMP, 32'h300, 32'h300, "ot_flags");
    xfer(1'b1, `OFF_CONFIG, 32'h80);
    `CHK("ots_disabled", 1'b0, overtemp_shutdown_action)
    active_state <= 1'b0;
    repeat (30) @(posedge pclk);
    base = starts.size();
    repeat (60) @(posedge pclk);
    `CHK("no_new_starts", base, starts.size())
    k = 0;
    nod = 0;
    foreach (starts[i]) begin
      if (starts[i] >= 3'd4) nod++;
      else begin
        `CHK("loop_step", pat[k % 6], starts[i])
        k++;
      end
    end
    `CHK("od_count", 4, nod)
    print_verdict();
  end
endmodule : tb_monitor_adc_sequencer
`default_nettype wire
